// >>> fasp_pkg.sv
// Purpose: Shared constants and types for the fast serial block transfer registers
// Assumes: AXI4-Lite register access, 200 MHz system clock
// Notes:   Printed offsets are not all multiples of four, so they are indices

package fasp_pkg;

  // ****************************************
  // Register map (indices, byte addr = 4*idx)
  // ****************************************
  localparam logic [15:0] IDX_SERIAL_DATA    = 16'hc076;
  localparam logic [15:0] IDX_RX_BASE_ADDR   = 16'hc078;
  localparam logic [15:0] IDX_RX_LEN_COUNTER = 16'hc07a;
  localparam logic [15:0] IDX_TX_GAP         = 16'hc074;
  localparam logic [15:0] IDX_CONTROL        = 16'hc070;
  localparam logic [15:0] IDX_IRQ_STATUS     = 16'hc06c;
  localparam logic [15:0] IDX_IRQ_MASK       = 16'hc06e;

  // ****************************************
  // Reset values and field layout
  // ****************************************
  localparam logic [15:0] TX_GAP_RESET     = 16'h0009;
  localparam logic [7:0]  GAP_BIAS         = 8'h07;
  localparam logic [9:0]  RX_COUNT_DONE    = 10'h3ff;
  localparam int          CTL_BLOCK_TX_BIT = 0;
  localparam int          CTL_ONE_STOP_BIT = 1;
  localparam int          CTL_TX_READY_BIT = 2;
  localparam int          CTL_RX_READY_BIT = 3;
  localparam int          CTL_RX_BUSY_BIT  = 4;
  localparam int          IRQ_BITS         = 3;
  localparam int          IRQ_RX_BYTE      = 0;
  localparam int          IRQ_TX_DONE      = 1;
  localparam int          IRQ_RX_BLOCK     = 2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ      = 200_000_000;
  localparam int BAUD_DEFAULT = 2_000_000;
  localparam int BIT_CYCLES  = CLK_HZ / BAUD_DEFAULT;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
  } fasp_mem_wr_t;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} fasp_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} fasp_rx_state_t;

endpackage

// >>> fasp_regs.sv
// Purpose: Fast serial port with byte and block receive, AXI4-Lite registers
// Assumes: Single clock, serial rx pin asynchronous, memory write port always ready
// Notes:   Block transmit moves bytes written to the data register only
// How it works
// (R1) Gap register only used while block transmit mode is on.
// (R2) In block mode, gap sets stop bits, overriding one-stop-bit option.
// (R3) Gap register resets to 0x0009, two stop bits.
// (R4) Idle time after a byte equals gap minus seven bit times.
// (R5) Data register read returns last byte received outside block receive.
// (R6) Received byte valid only while receive-ready flag is one.
// (R7) Writing data register sends exactly one byte from low bits.
// (R8) Software checks transmit-ready before writing the data register.
// (R9) Receive address register gives the block receive base address.
// (R10) Loading counter with count minus one starts block receive.
// (R11) Counter decrements once per byte received in block receive.
// (R12) Counter read returns remaining length minus one during the transfer.
// (R13) Counter reads 0x3ff after completion until software reloads it.
// (R14) Software writes zero to reserved bits.
// (R15) Each block byte stored at base plus running offset.
`timescale 1ns/1ps

module fasp_regs
  import fasp_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              serial_rx,
  output logic                   serial_tx,
  output fasp_pkg::fasp_mem_wr_t mem_wr,
  output logic                   irq
);
  import fasp_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] tx_gap;
  logic [7:0]  rx_data;
  logic [15:0] rx_base;
  logic [9:0]  rx_count;
  logic [15:0] rx_offset;
  logic        rx_block;
  logic        rx_ready;
  logic        block_tx;
  logic        one_stop;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_mask;

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  logic        aw_held;
  logic        w_held;
  logic [15:0] aw_idx;
  logic [15:0] w_data;
  logic        w_lo;
  logic        wr_fire;
  logic        rd_fire;
  logic        aw_ok;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign aw_ok   = (aw_idx == IDX_SERIAL_DATA) || (aw_idx == IDX_RX_BASE_ADDR) ||
                   (aw_idx == IDX_RX_LEN_COUNTER) || (aw_idx == IDX_TX_GAP) ||
                   (aw_idx == IDX_CONTROL) || (aw_idx == IDX_IRQ_STATUS) ||
                   (aw_idx == IDX_IRQ_MASK);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_idx        <= 16'h0000;
      w_data        <= 16'h0000;
      w_lo          <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[17:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[15:0];
        w_lo   <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic we_data, we_count, we_base, we_gap, we_ctl, we_stat, we_mask;
  assign we_data  = wr_fire && w_lo && (aw_idx == IDX_SERIAL_DATA);
  assign we_count = wr_fire && w_lo && (aw_idx == IDX_RX_LEN_COUNTER);
  assign we_base  = wr_fire && w_lo && (aw_idx == IDX_RX_BASE_ADDR);
  assign we_gap   = wr_fire && w_lo && (aw_idx == IDX_TX_GAP);
  assign we_ctl   = wr_fire && w_lo && (aw_idx == IDX_CONTROL);
  assign we_stat  = wr_fire && w_lo && (aw_idx == IDX_IRQ_STATUS);
  assign we_mask  = wr_fire && w_lo && (aw_idx == IDX_IRQ_MASK);

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  logic [15:0] ar_idx;
  logic [15:0] rd_val;
  logic        rd_ok;
  logic        tx_busy;
  assign ar_idx  = s_axi_araddr[17:2];
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_val = 16'h0000;
    rd_ok  = 1'b1;
    case (ar_idx)
      IDX_SERIAL_DATA:    rd_val = {8'h00, rx_data};  // see (R5)
      IDX_RX_BASE_ADDR:   rd_val = rx_base;
      IDX_RX_LEN_COUNTER: rd_val = {6'h00, rx_count}; // see (R12)
      IDX_TX_GAP:         rd_val = tx_gap;
      IDX_CONTROL:        rd_val = {11'h000, rx_block, rx_ready, !tx_busy, one_stop, block_tx};
      IDX_IRQ_STATUS:     rd_val = {13'h0000, irq_status};
      IDX_IRQ_MASK:       rd_val = {13'h0000, irq_mask};
      default:            rd_ok  = 1'b0;
    endcase
  end

  logic rd_take;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rd_val};
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // Reading data register consumes the byte
  assign rd_take = rd_fire && (ar_idx == IDX_SERIAL_DATA);

  // ****************************************
  // Control and gap registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_gap   <= TX_GAP_RESET; // see (R3)
      rx_base  <= 16'h0000;
      block_tx <= 1'b0;
      one_stop <= 1'b0;
      irq_mask <= '0;
    end else begin
      if (we_gap)  tx_gap   <= {8'h00, w_data[7:0]};
      if (we_base) rx_base  <= w_data; // see (R9)
      if (we_ctl) begin
        block_tx <= w_data[CTL_BLOCK_TX_BIT];
        one_stop <= w_data[CTL_ONE_STOP_BIT];
      end
      if (we_mask) irq_mask <= w_data[IRQ_BITS-1:0];
    end
  end

  // ****************************************
  // Bit-rate divider
  // ****************************************
  logic [15:0] tx_div;
  logic        tx_tick;
  assign tx_tick = (tx_div == 16'(BIT_CYC - 1));

  // ****************************************
  // Transmitter
  // ****************************************
  fasp_tx_state_t tx_state;
  logic [7:0]     tx_shift;
  logic [2:0]     tx_bit;
  logic [7:0]     stop_left;
  logic [7:0]     stop_bits;
  logic           tx_done_evt;

  // Stop bits: gap-7 in block mode (one when gap is 7 or less), else one or two per control bit
  always_comb begin
    if (block_tx) begin                                 // see (R1)
      stop_bits = (tx_gap[7:0] > GAP_BIAS) ? tx_gap[7:0] - GAP_BIAS : 8'h01; // see (R2) (R4)
    end else begin
      stop_bits = one_stop ? 8'h01 : 8'h02;
    end
  end
  assign tx_busy = (tx_state != TX_IDLE);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_state    <= TX_IDLE;
      tx_shift    <= 8'h00;
      tx_bit      <= 3'h0;
      stop_left   <= 8'h00;
      tx_div      <= 16'h0000;
      serial_tx   <= 1'b1;
      tx_done_evt <= 1'b0;
    end else begin
      tx_done_evt <= 1'b0;
      tx_div      <= (tx_tick || !tx_busy) ? 16'h0000 : tx_div + 16'h0001;
      case (tx_state)
        TX_IDLE: begin
          // Write while busy is ignored so the frame on the wire stays intact
          if (we_data) begin                            // see (R7) (R8)
            tx_shift  <= w_data[7:0];
            tx_state  <= TX_START;
            serial_tx <= 1'b0;
          end
        end
        TX_START: begin
          if (tx_tick) begin
            tx_state  <= TX_DATA;
            tx_bit    <= 3'h0;
            serial_tx <= tx_shift[0];
          end
        end
        TX_DATA: begin
          if (tx_tick) begin
            if (tx_bit == 3'h7) begin
              tx_state  <= TX_STOP;
              stop_left <= stop_bits;
              serial_tx <= 1'b1;
            end else begin
              tx_bit    <= tx_bit + 3'h1;
              tx_shift  <= {1'b0, tx_shift[7:1]};
              serial_tx <= tx_shift[1];
            end
          end
        end
        TX_STOP: begin
          if (tx_tick) begin
            if (stop_left <= 8'h01) begin
              tx_state    <= TX_IDLE;
              tx_done_evt <= 1'b1;
            end else begin
              stop_left <= stop_left - 8'h01;
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  logic           rx_meta, rx_sync;
  fasp_rx_state_t rx_state;
  logic [15:0]    rx_div;
  logic [2:0]     rx_bit;
  logic [7:0]     rx_shift;
  logic           rx_byte_evt;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= serial_rx;
      rx_sync <= rx_meta;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_state    <= RX_IDLE;
      rx_div      <= 16'h0000;
      rx_bit      <= 3'h0;
      rx_shift    <= 8'h00;
      rx_byte_evt <= 1'b0;
    end else begin
      rx_byte_evt <= 1'b0;
      rx_div      <= rx_div + 16'h0001;
      case (rx_state)
        RX_IDLE: begin
          rx_div <= 16'h0000;
          if (!rx_sync) rx_state <= RX_START;
        end
        RX_START: begin
          // Sample mid-bit to ride out edge skew
          if (rx_div == 16'(BIT_CYC / 2 - 1)) begin
            rx_div   <= 16'h0000;
            rx_bit   <= 3'h0;
            rx_state <= rx_sync ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_div == 16'(BIT_CYC - 1)) begin
            rx_div   <= 16'h0000;
            rx_shift <= {rx_sync, rx_shift[7:1]};
            rx_bit   <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_div == 16'(BIT_CYC - 1)) begin
            rx_state    <= RX_IDLE;
            rx_byte_evt <= rx_sync; // Framing error drops the byte
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // ****************************************
  // Byte path and block receive
  // ****************************************
  logic blk_byte;
  assign blk_byte = rx_byte_evt && rx_block;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_data   <= 8'h00;
      rx_ready  <= 1'b0;
      rx_block  <= 1'b0;
      rx_count  <= 10'h000;
      rx_offset <= 16'h0000;
      mem_wr    <= '0;
    end else begin
      mem_wr.valid <= 1'b0;
      if (rx_byte_evt && !rx_block) begin
        rx_data  <= rx_shift;                  // see (R5)
        rx_ready <= 1'b1;                      // see (R6)
      end else if (rd_take) begin
        rx_ready <= 1'b0;
      end
      if (we_count) begin
        rx_count  <= w_data[9:0];              // see (R10)
        rx_block  <= 1'b1;
        rx_offset <= 16'h0000;
      end else if (blk_byte) begin
        mem_wr.valid <= 1'b1;
        mem_wr.addr  <= rx_base + rx_offset;   // see (R15)
        mem_wr.data  <= rx_shift;
        rx_offset    <= rx_offset + 16'h0001;
        rx_count     <= rx_count - 10'h001;    // see (R11) (R13)
        if (rx_count == 10'h000) rx_block <= 1'b0;
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic [IRQ_BITS-1:0] irq_set;
  assign irq_set = {blk_byte && (rx_count == 10'h000), tx_done_evt, rx_byte_evt && !rx_block};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= '0;
      irq       <= 1'b0;
    end else begin
      // Set wins over a same-cycle clear
      irq_status <= (irq_status & ~(we_stat ? w_data[IRQ_BITS-1:0] : '0)) | irq_set;
      irq        <= |(irq_status & irq_mask);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_gap_reset;
    @(posedge clk_sys) $rose(arst_n) |-> tx_gap == TX_GAP_RESET;
  endproperty
  a_gap_reset: assert property (p_gap_reset) else $error("gap reset wrong"); // see (R3)

  property p_block_stops;
    @(posedge clk_sys) disable iff (!arst_n)
      (tx_state == TX_DATA && tx_tick && tx_bit == 3'h7 && block_tx && tx_gap[7:0] > GAP_BIAS)
        |=> stop_left == $past(tx_gap[7:0]) - GAP_BIAS;
  endproperty
  a_block_stops: assert property (p_block_stops) else $error("gap stop count"); // see (R2) (R4)

  property p_nonblock_stops;
    @(posedge clk_sys) disable iff (!arst_n)
      (tx_state == TX_DATA && tx_tick && tx_bit == 3'h7 && !block_tx)
        |=> stop_left == ($past(one_stop) ? 8'h01 : 8'h02);
  endproperty
  a_nonblock_stops: assert property (p_nonblock_stops) else $error("gap leaked"); // see (R1)

  property p_tx_start;
    @(posedge clk_sys) disable iff (!arst_n)
      (we_data && !tx_busy) |=> (tx_state == TX_START && !serial_tx && tx_shift == $past(w_data[7:0]));
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx did not start"); // see (R7)

  property p_rx_byte;
    @(posedge clk_sys) disable iff (!arst_n)
      (rx_byte_evt && !rx_block) |=> (rx_ready && rx_data == $past(rx_shift));
  endproperty
  a_rx_byte: assert property (p_rx_byte) else $error("rx byte lost"); // see (R5) (R6)

  property p_count_load;
    @(posedge clk_sys) disable iff (!arst_n)
      we_count |=> (rx_block && rx_count == $past(w_data[9:0]));
  endproperty
  a_count_load: assert property (p_count_load) else $error("count load"); // see (R10)

  property p_count_dec;
    @(posedge clk_sys) disable iff (!arst_n)
      (blk_byte && !we_count) |=> rx_count == $past(rx_count) - 10'h001;
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("count decrement"); // see (R11) (R12)

  property p_count_done;
    @(posedge clk_sys) disable iff (!arst_n)
      (blk_byte && !we_count && rx_count == 10'h000) |=> (!rx_block && rx_count == RX_COUNT_DONE);
  endproperty
  a_count_done: assert property (p_count_done) else $error("done value"); // see (R13)

  property p_mem_addr;
    @(posedge clk_sys) disable iff (!arst_n)
      (blk_byte && !we_count) |=>
        (mem_wr.valid && mem_wr.addr == $past(rx_base) + $past(rx_offset));
  endproperty
  a_mem_addr: assert property (p_mem_addr) else $error("block store address"); // see (R15)

  c_tx: cover property (@(posedge clk_sys) tx_done_evt);
  c_blk_done: cover property (@(posedge clk_sys) blk_byte && rx_count == 10'h000);
  c_rx: cover property (@(posedge clk_sys) rx_byte_evt && !rx_block);

endmodule // fasp_regs

// >>> fasp_peer.sv
// Purpose: Remote serial peer facing the fast serial port
// Assumes: 8 data bits, LSB first, idle high, BIT_CYC clocks per bit
// Notes:   Logs each received byte and the cycle of its start bit
`timescale 1ns/1ps

module fasp_peer #(
  parameter int BIT_CYC = 8
) (
  input  wire logic clk_sys,
  input  wire logic line_in,
  output logic      line_out
);
  logic [7:0] rx_q[$];
  int         start_q[$];
  int         cyc;

  initial begin
    line_out = 1'b1;
    cyc      = 0;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
  end

  // ****************************************
  // Receive side
  // ****************************************
  // Stamp on the next edge so the count never races the line update
  initial begin : rx_proc
    logic [7:0] b;
    forever begin
      @(negedge line_in);
      @(posedge clk_sys);
      start_q.push_back(cyc);
      repeat (BIT_CYC / 2 - 1) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk_sys);
        b[i] = line_in;
      end
      repeat (BIT_CYC) @(posedge clk_sys);
      rx_q.push_back(b);
    end
  end

  // ****************************************
  // Send side
  // ****************************************
  // One stop bit only, so calls back to back give the tightest spacing
  task automatic send(input logic [7:0] b);
    @(posedge clk_sys);
    line_out <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CYC) @(posedge clk_sys);
      line_out <= (i < 8) ? b[i] : 1'b1;
    end
  endtask

endmodule // fasp_peer

// >>> fasp_regs_tb_top.sv
// Purpose: Self-checking bench for the fast serial port registers
// Assumes: Bit time shortened to 8 clocks
// Notes:   Gap checks allow two bit times of polling slack
`timescale 1ns/1ps

module fasp_regs_tb_top;
  import fasp_pkg::*;
  localparam int B = 8;

  // ****************************************
  // Signals and instances
  // ****************************************
  logic         clk_sys, arst_n, irq, serial_rx, serial_tx;
  logic [31:0]  awaddr, wdata, araddr, rdata;
  logic         awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready;
  logic [1:0]   bresp, rresp;
  logic [3:0]   wstrb;
  fasp_mem_wr_t mem_wr;
  fasp_mem_wr_t mw_q[$];
  int           mismatches = 0;
  int           compares = 0;

  fasp_regs #(.BIT_CYC(B)) DUT (
    .clk_sys(clk_sys), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_rx(serial_rx), .serial_tx(serial_tx), .mem_wr(mem_wr), .irq(irq));

  fasp_peer #(.BIT_CYC(B)) u_peer (.clk_sys(clk_sys), .line_in(serial_tx), .line_out(serial_rx));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (mem_wr.valid === 1'b1) mw_q.push_back(mem_wr);
  end

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic axi_wr(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    awaddr  <= {14'h0, idx, 2'b00};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (bvalid !== 1'b1) begin
      @(posedge clk_sys);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    araddr  <= {14'h0, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (rvalid !== 1'b1) begin
      @(posedge clk_sys);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s: got %h exp %h", $time, w, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string w);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s: got %b exp %b", $time, w, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(idx, d, r);
    chk({30'h0, r}, 32'h0, "write resp");
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp, input string w);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(idx, d, r);
    chk({30'h0, r}, 32'h0, "read resp");
    chk(d, exp, w);
  endtask

  task automatic rd_bit(input logic [15:0] idx, input int n, input logic exp, input string w);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(idx, d, r);
    chk_flag(d[n], exp, w);
  endtask

  // Bounded poll; gives up as a mismatch instead of hanging
  task automatic wait_bit(input logic [15:0] idx, input int n);
    logic [31:0] d;
    logic [1:0]  r;
    int          k;
    k = 0;
    do begin
      axi_rd(idx, d, r);
      k++;
    end while (d[n] !== 1'b1 && k < 400);
    chk_flag(d[n], 1'b1, "flag wait");
  endtask

  task automatic irq_is(input logic exp, input string w);
    repeat (2) @(posedge clk_sys);
    chk_flag(irq, exp, w);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(IDX_TX_GAP, 32'h0000_0009, "gap reset");
    // Low strobe off: the write must leave the gap untouched
    wstrb <= 4'h0;
    wr(IDX_TX_GAP, 32'h0000_0033);
    wstrb <= 4'hf;
    rd_chk(IDX_TX_GAP, 32'h0000_0009, "strobe off");
    rd_chk(IDX_RX_BASE_ADDR, 32'h0, "base reset");
    rd_chk(IDX_RX_LEN_COUNTER, 32'h0, "count reset");
    axi_rd(16'hc07c, d, r);
    chk({30'h0, r}, 32'h2, "unmapped read resp");
    chk(d, 32'h0, "unmapped read data");
    axi_wr(16'hc07c, 32'h1, r);
    chk({30'h0, r}, 32'h2, "unmapped write resp");
    $display("test reset done");
  endtask

  task automatic t_tx();
    wr(IDX_IRQ_MASK, 32'h0);
    u_peer.rx_q.delete();
    wait_bit(IDX_CONTROL, CTL_TX_READY_BIT);
    wr(IDX_SERIAL_DATA, 32'h0000_00a5);
    for (int k = 0; k < 4000 && u_peer.rx_q.size() < 1; k++) @(posedge clk_sys);
    wait_bit(IDX_CONTROL, CTL_TX_READY_BIT);
    chk(u_peer.rx_q.size(), 32'h1, "tx count");
    chk({24'h0, u_peer.rx_q[0]}, 32'ha5, "tx byte");
    rd_bit(IDX_IRQ_STATUS, IRQ_TX_DONE, 1'b1, "tx status");
    irq_is(1'b0, "masked irq");
    wr(IDX_IRQ_MASK, 32'h2);
    irq_is(1'b1, "unmasked irq");
    wr(IDX_IRQ_STATUS, 32'h2);
    irq_is(1'b0, "cleared irq");
    $display("test tx done");
  endtask

  task automatic t_gap();
    logic [31:0] ctl [5] = '{32'h3, 32'h2, 32'h0, 32'h1, 32'h1};
    logic [31:0] gap [5] = '{32'hc, 32'hc, 32'hc, 32'h8, 32'h9};
    int          stops [5] = '{5, 1, 2, 1, 2};
    int          idle;
    for (int k = 0; k < 5; k++) begin
      wr(IDX_CONTROL, ctl[k]);
      wr(IDX_TX_GAP, gap[k]);
      rd_chk(IDX_TX_GAP, gap[k], "gap readback");
      u_peer.rx_q.delete();
      u_peer.start_q.delete();
      repeat (2) begin
        wait_bit(IDX_CONTROL, CTL_TX_READY_BIT);
        wr(IDX_SERIAL_DATA, 32'h0000_005a);
      end
      for (int n = 0; n < 4000 && u_peer.rx_q.size() < 2; n++) @(posedge clk_sys);
      idle = u_peer.start_q[1] - u_peer.start_q[0] - 9 * B;
      chk_flag(idle >= stops[k]*B && idle < (stops[k]+2)*B, 1'b1, "gap");
    end
    $display("test gap done");
  endtask

  task automatic t_rx();
    wr(IDX_CONTROL, 32'h0);
    wr(IDX_IRQ_MASK, 32'h1);
    u_peer.send(8'h3c);
    wait_bit(IDX_CONTROL, CTL_RX_READY_BIT);
    chk_flag(irq, 1'b1, "rx irq");
    rd_chk(IDX_SERIAL_DATA, 32'h3c, "rx byte");
    rd_bit(IDX_CONTROL, CTL_RX_READY_BIT, 1'b0, "rx ready");
    wr(IDX_IRQ_STATUS, 32'h1);
    irq_is(1'b0, "rx irq cleared");
    $display("test rx done");
  endtask

  task automatic t_block();
    mw_q.delete();
    wr(IDX_IRQ_MASK, 32'h4);
    wr(IDX_RX_BASE_ADDR, 32'h1230);
    rd_chk(IDX_RX_BASE_ADDR, 32'h1230, "base");
    wr(IDX_RX_LEN_COUNTER, 32'h2);
    u_peer.send(8'h11);
    for (int n = 0; n < 4000 && mw_q.size() < 1; n++) @(posedge clk_sys);
    rd_chk(IDX_RX_LEN_COUNTER, 32'h1, "count mid");
    u_peer.send(8'h22);
    u_peer.send(8'h33);
    for (int n = 0; n < 4000 && mw_q.size() < 3; n++) @(posedge clk_sys);
    rd_chk(IDX_RX_LEN_COUNTER, 32'h3ff, "count done");
    chk(mw_q.size(), 32'h3, "store count");
    for (int k = 0; k < 3 && k < mw_q.size(); k++) begin
      chk({16'h0, mw_q[k].addr}, 32'h1230 + k, "store addr");
      chk({24'h0, mw_q[k].data}, 32'h11 * (k + 1), "store data");
    end
    rd_bit(IDX_CONTROL, CTL_RX_READY_BIT, 1'b0, "no byte path");
    chk_flag(irq, 1'b1, "block irq");
    wr(IDX_IRQ_STATUS, 32'h4);
    irq_is(1'b0, "block irq cleared");
    $display("test block done");
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    arst_n  = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb   = 4'hf;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_tx();
    t_gap();
    t_rx();
    t_block();
    tally_and_finish();
  end

  // Whole run needs a few thousand cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end

endmodule // fasp_regs_tb_top
